// file: rtl/cta_pkg.sv
// package: constants, command codes and carriers for the counter/timer array
package cta_pkg;

	// ----------------------------------------------------------------
	// array shape and clocking
	// ----------------------------------------------------------------
	localparam int          CTA_N        = 8;
	localparam int          CTA_W        = 32;
	localparam int          CTA_CLK_HZ   = 40_000_000;
	localparam int          CTA_SLOW_HZ  = 1_000_000;
	localparam int          CTA_SLOW_DIV = CTA_CLK_HZ / CTA_SLOW_HZ;
	localparam logic [5:0]  CTA_SLOW_TOP = 6'(CTA_SLOW_DIV - 1);

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0]  CTA_OFS_CMD    = 8'h00;
	localparam logic [7:0]  CTA_OFS_LOAD   = 8'h04;
	localparam logic [7:0]  CTA_OFS_SNAP   = 8'h08;
	localparam logic [7:0]  CTA_OFS_STATUS = 8'h0c;
	localparam logic [7:0]  CTA_OFS_PC_DIR = 8'h10;
	localparam logic [7:0]  CTA_OFS_PC_DAT = 8'h14;
	localparam logic [7:0]  CTA_OFS_IRQ_EN = 8'h18;

	// ----------------------------------------------------------------
	// command word field positions
	// ----------------------------------------------------------------
	localparam int          CTA_CODE_LSB = 0;
	localparam int          CTA_MASK_LSB = 8;
	localparam int          CTA_ARG_BIT  = 16;
	localparam int          CTA_SEL_LSB  = 20;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] CTA_CNT_RST  = 32'h0000_0000;
	localparam logic [7:0]  CTA_PC_RST   = 8'h00;

	// pulse widths in counter clock periods
	localparam logic [9:0]  CTA_PW_1     = 10'h001;
	localparam logic [9:0]  CTA_PW_10    = 10'h00a;
	localparam logic [9:0]  CTA_PW_100   = 10'h064;
	localparam logic [9:0]  CTA_PW_1000  = 10'h3e8;

	typedef enum logic [3:0] {
		CTA_C_CLEAR  = 4'b0000,
		CTA_C_LOAD   = 4'b0001,
		CTA_C_DIR    = 4'b0010,
		CTA_C_ENABLE = 4'b0100,
		CTA_C_LATCH  = 4'b0101,
		CTA_C_CLKSRC = 4'b0110,
		CTA_C_RELOAD = 4'b0111,
		CTA_C_OUTEN  = 4'b1000,
		CTA_C_WIDTH  = 4'b1001,
		CTA_C_READ   = 4'b1010,
		CTA_C_RESET  = 4'b1111
	} cta_code_t;

	typedef enum logic [1:0] {
		CTA_CS_FAST = 2'b00,
		CTA_CS_SLOW = 2'b01,
		CTA_CS_EXT  = 2'b10
	} cta_csrc_t;

	// one decoded command
	typedef struct packed {
		logic       valid;
		logic [3:0] code;
		logic [7:0] mask;
		logic       arg;
		logic [1:0] sel;
	} cta_cmd_t;

endpackage

// file: rtl/cta_top.sv
// counter/timer array: eight 32-bit counters with a Wishbone command port
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ps

// Functional notes
// - eight independent 32-bit counters
// - each counts up or down
// - clock from fast, slow or external source
// - command 6 picks clock source
// - down mode: optional pulse at zero
// - counters can raise host interrupts
// - mask selects which counters obey command
// - command 0 clears count, run state kept
// - command 1 loads 32-bit host value
// - command 2 sets count direction
// - command 4 enables/disables; disabled holds value
// - command 5 snapshots count, keeps counting
// - command 7 sets auto-reload
// - command 8 routes pulse to pin
// - command 9 sets width 1/10/100/1000
// - command 15 resets configuration and count
// - counter n uses port C pin n
// - pin is clock or pulse output, never both
// - port C bitwise direction, else general-purpose
// - reset: pins input, data registers zero
module cta_top
	import cta_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [7:0]  pc_i,
	output logic      [7:0]  pc_o,
	output logic      [7:0]  pc_oe_n_o,
	output logic             irq_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [31:0] cnt      [CTA_N];
	logic [31:0] reload   [CTA_N];
	logic [31:0] snap     [CTA_N];
	logic [7:0]  dir_down;
	logic [7:0]  run;
	logic [7:0]  arel;
	logic [7:0]  outen;
	logic [7:0]  pulse;
	logic [7:0]  zero_evt;
	logic [1:0]  csrc     [CTA_N];
	logic [1:0]  pw_sel   [CTA_N];
	logic [31:0] load_val;
	logic [31:0] snap_rd;
	logic [2:0]  rd_idx;
	logic [7:0]  pc_dir;
	logic [7:0]  pc_dat;
	logic [7:0]  irq_en;
	logic [7:0]  ext_s1;
	logic [7:0]  ext_s2;
	logic [7:0]  ext_s3;
	logic [5:0]  slow_cnt;
	logic        slow_en;
	cta_cmd_t    cmd;
	logic        wr;
	logic        rd;

	// ----------------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------------

	// ack one cycle after the strobe; writes land on the acked edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
		end
	end

	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

	// a write to the command word issues it; needs the low three lanes
	always_comb begin
		cmd       = '0;
		cmd.valid = wr & (wb_adr_i == CTA_OFS_CMD) & (&wb_sel_i[2:0]);
		cmd.code  = wb_dat_i[CTA_CODE_LSB +: 4];
		cmd.mask  = wb_dat_i[CTA_MASK_LSB +: 8];
		cmd.arg   = wb_dat_i[CTA_ARG_BIT];
		cmd.sel   = wb_dat_i[CTA_SEL_LSB +: 2];
	end

	// plain data registers, byte lanes honoured
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			load_val <= CTA_CNT_RST;
			pc_dir   <= CTA_PC_RST;
			pc_dat   <= CTA_PC_RST;
			irq_en   <= 8'h00;
		end else if (wr) begin
			if (wb_adr_i == CTA_OFS_LOAD) begin
				for (int b = 0; b < 4; b++) begin
					if (wb_sel_i[b]) begin
						load_val[8*b +: 8] <= wb_dat_i[8*b +: 8];
					end
				end
			end else if (wb_adr_i == CTA_OFS_PC_DIR && wb_sel_i[0]) begin
				pc_dir <= wb_dat_i[7:0];
			end else if (wb_adr_i == CTA_OFS_PC_DAT && wb_sel_i[0]) begin
				pc_dat <= wb_dat_i[7:0];
			end else if (wb_adr_i == CTA_OFS_IRQ_EN && wb_sel_i[0]) begin
				irq_en <= wb_dat_i[7:0];
			end
		end
	end

	// read mux; unmapped addresses read zero and still ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd) begin
			if (wb_adr_i == CTA_OFS_LOAD) begin
				wb_dat_o <= load_val;
			end else if (wb_adr_i == CTA_OFS_SNAP) begin
				wb_dat_o <= snap_rd;
			end else if (wb_adr_i == CTA_OFS_STATUS) begin
				wb_dat_o <= {5'h00, rd_idx, arel, pulse, run};
			end else if (wb_adr_i == CTA_OFS_PC_DIR) begin
				wb_dat_o <= {24'h000000, pc_dir};
			end else if (wb_adr_i == CTA_OFS_PC_DAT) begin
				wb_dat_o <= {24'h000000, pc_i};
			end else if (wb_adr_i == CTA_OFS_IRQ_EN) begin
				wb_dat_o <= {24'h000000, irq_en};
			end else begin
				wb_dat_o <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// read-back of the latched value
	// ----------------------------------------------------------------

	// lowest selected counter wins when several are masked
	function automatic logic [2:0] cta_first(input logic [7:0] m);
		logic [2:0] idx;
		idx = 3'h0;
		for (int k = CTA_N - 1; k >= 0; k--) begin
			if (m[k]) begin
				idx = 3'(k);
			end
		end
		return idx;
	endfunction

	// read only shows the snapshot, never the live count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_idx  <= 3'h0;
			snap_rd <= CTA_CNT_RST;
		end else if (cmd.valid && cmd.code == CTA_C_READ && cmd.mask != 8'h00) begin
			rd_idx  <= cta_first(cmd.mask);
			snap_rd <= snap[cta_first(cmd.mask)];
		end
	end

	// ----------------------------------------------------------------
	// slow internal clock enable
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slow_cnt <= 6'h00;
			slow_en  <= 1'b0;
		end else begin
			slow_en  <= (slow_cnt == CTA_SLOW_TOP);
			slow_cnt <= (slow_cnt == CTA_SLOW_TOP) ? 6'h00 : slow_cnt + 6'h01;
		end
	end

	// ----------------------------------------------------------------
	// external clock synchroniser, pin inputs
	// ----------------------------------------------------------------

	// s1 feeds only s2; edges are judged between s2 and s3
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_s1 <= 8'h00;
			ext_s2 <= 8'h00;
			ext_s3 <= 8'h00;
		end else begin
			ext_s1 <= pc_i;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end

	// interrupt: one-cycle pulse when an enabled counter hits zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(zero_evt & irq_en);
		end
	end

	// ----------------------------------------------------------------
	// the counters
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < CTA_N; gi++) begin : g_ctr
			logic        hit;
			logic        src_en;
			logic        tick;
			logic        term;
			logic        use_pin;
			logic [31:0] next_cnt;
			logic [9:0]  pcnt;
			logic [9:0]  width;

			assign hit = cmd.valid & cmd.mask[gi];

			// count enable from the chosen source
			always_comb begin
				case (csrc[gi])
					CTA_CS_FAST: src_en = 1'b1;
					CTA_CS_SLOW: src_en = slow_en;
					CTA_CS_EXT:  src_en = ext_s2[gi] & ~ext_s3[gi];
					default:     src_en = 1'b0;
				endcase
			end

			assign tick = run[gi] & src_en;
			assign term = dir_down[gi] ? (cnt[gi] == 32'h0000_0000)
			                           : (cnt[gi] == 32'hffff_ffff);

			// next value: reload at terminal count when auto-reload is set, else step
			always_comb begin
				if (term && arel[gi]) begin
					next_cnt = reload[gi];
				end else if (dir_down[gi]) begin
					next_cnt = cnt[gi] - 32'h0000_0001;
				end else begin
					next_cnt = cnt[gi] + 32'h0000_0001;
				end
			end

			assign zero_evt[gi] = tick & ~hit & (next_cnt == 32'h0000_0000);

			// configuration; unlisted codes fall through untouched
			always_ff @(posedge clk_i) begin
				if (rst_i || (hit && cmd.code == CTA_C_RESET)) begin
					dir_down[gi] <= 1'b0;
					run[gi]      <= 1'b0;
					arel[gi]     <= 1'b0;
					outen[gi]    <= 1'b0;
					csrc[gi]     <= CTA_CS_FAST;
					pw_sel[gi]   <= 2'b00;
				end else if (hit) begin
					case (cmd.code)
						CTA_C_DIR:    dir_down[gi] <= cmd.arg;
						CTA_C_ENABLE: run[gi]      <= cmd.arg;
						CTA_C_CLKSRC: csrc[gi]     <= cmd.sel;
						CTA_C_RELOAD: arel[gi]     <= cmd.arg;
						CTA_C_OUTEN:  outen[gi]    <= cmd.arg;
						CTA_C_WIDTH:  pw_sel[gi]   <= cmd.sel;
						default: ;
					endcase
				end
			end

			// count register; reset, clear or load beats a tick in the same cycle
			always_ff @(posedge clk_i) begin
				if (rst_i || (hit && cmd.code == CTA_C_RESET)) begin
					cnt[gi]    <= CTA_CNT_RST;
					reload[gi] <= CTA_CNT_RST;
				end else if (hit && cmd.code == CTA_C_CLEAR) begin
					cnt[gi] <= CTA_CNT_RST;
				end else if (hit && cmd.code == CTA_C_LOAD) begin
					cnt[gi]    <= load_val;
					reload[gi] <= load_val;
				end else if (tick) begin
					cnt[gi] <= next_cnt;
				end
			end

			// snapshot; the count is left running
			always_ff @(posedge clk_i) begin
				if (rst_i || (hit && cmd.code == CTA_C_RESET)) begin
					snap[gi] <= CTA_CNT_RST;
				end else if (hit && cmd.code == CTA_C_LATCH) begin
					snap[gi] <= cnt[gi];
				end
			end

			// width in source clock periods
			always_comb begin
				case (pw_sel[gi])
					2'b00:   width = CTA_PW_1;
					2'b01:   width = CTA_PW_10;
					2'b10:   width = CTA_PW_100;
					default: width = CTA_PW_1000;
				endcase
			end

			// pulse at zero in down mode only, timed by source clock
			always_ff @(posedge clk_i) begin
				if (rst_i || (hit && cmd.code == CTA_C_RESET)) begin
					pulse[gi] <= 1'b0;
					pcnt      <= 10'h000;
				end else if (zero_evt[gi] && dir_down[gi] && outen[gi]) begin
					pulse[gi] <= 1'b1;
					pcnt      <= width - 10'h001;
				end else if (pulse[gi] && src_en) begin
					if (pcnt == 10'h000) begin
						pulse[gi] <= 1'b0;
					end else begin
						pcnt <= pcnt - 10'h001;
					end
				end
			end

			// pin n belongs to counter n; an external clock keeps the pulse off it, a routed pulse or pc_dir makes it an output
			assign use_pin = outen[gi] & (csrc[gi] != CTA_CS_EXT);
			assign pc_o[gi]      = use_pin ? pulse[gi] : pc_dat[gi];
			assign pc_oe_n_o[gi] = ~(use_pin | pc_dir[gi]);
		end
	endgenerate

endmodule

// file: verification/cta_pins.sv
// port C pin model: device drive, outside source, else pull-down
`timescale 1ns/1ps
module cta_pins (
	input  wire logic [7:0] dev_o_i,
	input  wire logic [7:0] dev_oe_n_i,
	input  wire logic [7:0] ext_en_i,
	input  wire logic [7:0] ext_val_i,
	output logic      [7:0] pin_o
);
	// ----------------------------------------
	// wire resolution
	// ----------------------------------------
	// released lines take the outside source or fall to the pull-down, never keep a stale level
	always_comb begin
		for (int n = 0; n < 8; n++) begin
			pin_o[n] = !dev_oe_n_i[n] ? dev_o_i[n] : (ext_en_i[n] && ext_val_i[n]);
		end
	end
endmodule

// file: verification/cta_monitor.sv
// checker for the counter/timer array bus port and pins
`timescale 1ns/1ps
module cta_monitor
	import cta_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [7:0]  pc_i,
	input wire logic [7:0]  pc_o,
	input wire logic [7:0]  pc_oe_n_o,
	input wire logic        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic rd;
	// read answer qualifier
	assign rd = wb_ack_o && !wb_we_i;
	// ----------------------------------------
	// handshake, read data and pin state
	// ----------------------------------------
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	ack_idle_a: assert property (!wb_cyc_i |=> !wb_ack_o)
		else $error("ack without cycle");
	cmd_rd_a: assert property (rd && wb_adr_i == CTA_OFS_CMD |-> wb_dat_o == 32'h0)
		else $error("command word read back");
	hole_rd_a: assert property (rd && wb_adr_i > CTA_OFS_IRQ_EN |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	pin_rd_a: assert property (rd && wb_adr_i == CTA_OFS_PC_DAT |-> wb_dat_o == {24'h0, $past(pc_i)})
		else $error("pin read wrong");
	rst_pins_a: assert property ($fell(rst_i) |-> pc_oe_n_o == 8'hff && pc_o == 8'h00 && !irq_o)
		else $error("pins not idle after reset");
	dir_cause_a: assert property ($changed(pc_oe_n_o) |-> $past(wb_ack_o && wb_we_i) || $past(rst_i))
		else $error("direction changed without write");
	// main scenarios
	cover property (wb_ack_o && wb_we_i);
	cover property ($rose(irq_o));
	cover property ($changed(pc_oe_n_o));
endmodule
bind cta_top cta_monitor cta_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .pc_i(pc_i), .pc_o(pc_o), .pc_oe_n_o(pc_oe_n_o), .irq_o(irq_o));

// file: verification/cta_top_test.sv
// self-checking bench for the counter/timer array
`timescale 1ns/1ps
module cta_top_test
	import cta_pkg::*;
;
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, irq;
	logic [7:0]  adr = 0, pc_i, pc_o, oe_n, ext_val = 0;
	logic [31:0] wdat = 0, dout, rdat;
	int          error_cnt = 0, n_compared = 0, k;
	cta_top cta_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dout),
		.wb_ack_o(ack), .pc_i(pc_i), .pc_o(pc_o), .pc_oe_n_o(oe_n), .irq_o(irq));
	cta_pins cta_pins_i (.dev_o_i(pc_o), .dev_oe_n_i(oe_n), .ext_en_i(8'h08),
		.ext_val_i(ext_val), .pin_o(pc_i));
	// ----------------------------------------
	// clock, tasks
	// ----------------------------------------
	initial forever #12.5 clk_i = ~clk_i;
	task automatic wrap_up;
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask
	// one classic cycle; data taken at the ack edge, then a low cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = dout;
		cyc <= 0; stb <= 0; we <= 0;
		@(posedge clk_i);
	endtask
	task automatic cmd(input logic [3:0] c, input logic [7:0] m, input logic a,
		input logic [1:0] s);
		wb(1'b1, CTA_OFS_CMD, {10'h0, s, 3'h0, a, m, 4'h0, c});
	endtask
	task automatic cnt(input int n, input logic [31:0] e);
		cmd(CTA_C_LATCH, 8'(1 << n), 1'b0, 2'd0);
		cmd(CTA_C_READ, 8'(1 << n), 1'b0, 2'd0);
		wb(1'b0, CTA_OFS_SNAP, 32'h0);
		chk("count", e, rdat);
	endtask
	// outside clock on pin 3, slow enough for the resync
	task automatic ext(input int n);
		repeat (n) begin
			ext_val[3] <= 1;
			repeat (4) @(posedge clk_i);
			ext_val[3] <= 0;
			repeat (4) @(posedge clk_i);
		end
	endtask
	task automatic span(input int n, input logic v);
		k = 0;
		while (pc_o[n] === v && k < 2000) begin
			@(posedge clk_i);
			k++;
		end
	endtask
	// hang guard, far beyond the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		wrap_up;
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk("dir", 32'hff, 32'(oe_n));
		wb(1'b0, CTA_OFS_PC_DIR, 32'h0); chk("pc_dir", 32'h0, rdat);
		wb(1'b0, CTA_OFS_PC_DAT, 32'h0); chk("pc_dat", 32'h0, rdat);
		wb(1'b0, 8'h1c, 32'h0); chk("hole", 32'h0, rdat);
		$display("test reset done");
		wb(1'b1, CTA_OFS_LOAD, 32'h0000_0100);
		cmd(CTA_C_LOAD, 8'h05, 1'b0, 2'd0);
		cnt(2, 32'h0000_0100);
		cnt(1, 32'h0);
		$display("test load done");
		cmd(CTA_C_CLKSRC, 8'h08, 1'b0, 2'd2);
		cmd(CTA_C_ENABLE, 8'h08, 1'b1, 2'd0);
		cmd(CTA_C_OUTEN, 8'h08, 1'b1, 2'd0);
		chk("ext pin", 32'h1, 32'(oe_n[3]));
		ext(5); cnt(3, 32'h5);
		cmd(CTA_C_CLEAR, 8'h08, 1'b0, 2'd0);
		ext(2); cnt(3, 32'h2);
		cmd(CTA_C_ENABLE, 8'h08, 1'b0, 2'd0);
		ext(3); cnt(3, 32'h2);
		// undefined codes 3 and 11 to 14, every counter selected
		for (int i = 0; i < 5; i++) begin
			cmd(4'(i < 1 ? 3 : i + 10), 8'hff, 1'b1, 2'd3);
		end
		cnt(3, 32'h2);
		cmd(CTA_C_RESET, 8'h08, 1'b0, 2'd0);
		ext(1); cnt(3, 32'h0);
		$display("test external done");
		wb(1'b1, CTA_OFS_LOAD, 32'h2);
		cmd(CTA_C_LOAD, 8'h03, 1'b0, 2'd0);
		cmd(CTA_C_DIR, 8'h03, 1'b1, 2'd0);
		cmd(CTA_C_WIDTH, 8'h01, 1'b0, 2'd1);
		cmd(CTA_C_RELOAD, 8'h02, 1'b1, 2'd0);
		cmd(CTA_C_OUTEN, 8'h03, 1'b1, 2'd0);
		wb(1'b1, CTA_OFS_IRQ_EN, 32'h2);
		chk("out pins", 32'h0, 32'(oe_n[1:0]));
		cmd(CTA_C_ENABLE, 8'h03, 1'b1, 2'd0);
		span(0, 1'b0); span(0, 1'b1); chk("width", 32'd10, 32'(k));
		span(1, 1'b1); span(1, 1'b0); span(1, 1'b1); chk("reload hi", 32'd1, 32'(k));
		span(1, 1'b0); chk("reload lo", 32'd2, 32'(k));
		k = 0;
		while (irq !== 1'b1 && k < 20) begin @(posedge clk_i); k++; end
		chk("irq", 32'h1, 32'(irq));
		wb(1'b0, CTA_OFS_STATUS, 32'h0);
		chk("status", 32'h0203, {16'h0, rdat[23:16], rdat[7:0]});
		wb(1'b1, CTA_OFS_IRQ_EN, 32'h0);
		k = 0;
		repeat (12) begin @(posedge clk_i); if (irq === 1'b1) k++; end
		chk("irq masked", 32'h0, 32'(k));
		$display("test pulse done");
		wrap_up;
	end
endmodule
